/* File: logic/mmd_map.svh */
// Notes on behaviour
// - On-chip 128-byte RAM answers at 0x0000 to 0x007F.
// - Peripheral control registers occupy 128 bytes from 0x0100; a select flags them.
// - The 4K region from 0x1000 is memory-mapped I/O, holding the display.
// - External 8K static RAM is selected for 0x2000 to 0x3FFF.
// - The 32K region from 0x4000 goes to the cartridge port.
// - The 8K window from 0xC000 selects the paged system ROM.
// - The 4K region from 0xE000 maps to nothing.
// - On-chip 4K mask ROM answers at 0xF000, flagged by its own select.
// - Four chip selects come from the top five address bits alone.
// - Selects serve display, external RAM, cartridge and system ROM, in that order.
// - Two page lines drive the top system ROM address bits, choosing 8K pages.
// - Accesses in the slow range stretch the CPU cycle, since no wait states exist.
// - Slow divide ratio comes from software; the slow range is fixed.
// - Every display transfer is slowed, at least one display clock period long.
// - Display uses eight data lines, read/write, address bit and one select.
// - Address and data leave on separate buses; no latching of low address.
// - Cartridge sees address, data, read/write and an active-low select.
`ifndef MMD_MAP_SVH
`define MMD_MAP_SVH
`define MMD_IRAM_END 16'h0080
`define MMD_PERI_BASE 16'h0100
`define MMD_PERI_END 16'h0180
`define MMD_TOP5_IO0 5'h02
`define MMD_TOP5_IO1 5'h03
`define MMD_TOP3_XRAM 3'h1
`define MMD_TOP2_CART0 2'h1
`define MMD_TOP2_CART1 2'h2
`define MMD_TOP3_SROM 3'h6
`define MMD_TOP4_IROM 4'hF
`define MMD_CS_DISP 0
`define MMD_CS_XRAM 1
`define MMD_CS_CART 2
`define MMD_CS_SROM 3
`define MMD_CS_IDLE 4'hF
`define MMD_IRAM_AW 7
`define MMD_CNT_W 8
`define MMD_DIV_W 4
`define MMD_BASE_CYC 6
`define MMD_CLK_KHZ 25000
`define MMD_DISP_CLK_KHZ 270
`define MMD_DISP_MIN_CYC ((`MMD_CLK_KHZ + `MMD_DISP_CLK_KHZ - 1) / `MMD_DISP_CLK_KHZ)
`endif

/* File: logic/mmd_pkg.sv */
`include "mmd_map.svh"
package mmd_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_BUSY
	} mmd_fsm_e;
	typedef enum logic [2:0] {
		RG_NONE,
		RG_IRAM,
		RG_PERI,
		RG_DISP,
		RG_XRAM,
		RG_CART,
		RG_SROM,
		RG_IROM
	} mmd_region_e;
	typedef struct packed {
		mmd_fsm_e st;
		mmd_region_e region;
		logic [`MMD_CNT_W-1:0] cnt;
		logic [15:0] addr;
		logic we;
		logic [7:0] dout;
		logic doe;
		logic rw_n;
		logic [3:0] cs_n;
		logic [1:0] page;
		logic peri;
		logic irom;
		logic busy;
		logic slowed;
		logic ack;
		logic [7:0] rdata;
		logic [7:0] s1;
		logic [7:0] s2;
		logic [7:0] s3;
		logic [7:0] dstab;
	} mmd_state_s;
endpackage

/* File: logic/mmd_ram.sv */
`timescale 1ns/1ps
`include "mmd_map.svh"
module mmd_ram #(
	parameter int AW = `MMD_IRAM_AW,
	parameter int DW = 8
) (
	// Clock, reset and enable
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	// Access
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Contents are not reset; software treats on-chip RAM as undefined at power-up.
	always_ff @(posedge mclk) begin
		if (ce && we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= '0;
		end else if (ce) begin
			rdata <= mem[addr];
		end
	end
endmodule

/* File: logic/mmd_decoder.sv */
`timescale 1ns/1ps
`include "mmd_map.svh"
module mmd_decoder #(
	parameter int BASE_CYC = `MMD_BASE_CYC,
	parameter int DIV_W = `MMD_DIV_W
) (
	// Clock, reset and enable
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	// CPU access port
	input wire logic cpu_req,
	input wire logic cpu_we,
	input wire logic [15:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	output logic cpu_ack,
	output logic [7:0] cpu_rdata,
	output logic cpu_busy,
	output logic cpu_slowed,
	// Software settings from the general-purpose output port
	input wire logic [DIV_W-1:0] clk_div,
	input wire logic [1:0] rom_page_sel,
	// On-chip peripheral registers and mask ROM
	input wire logic [7:0] int_rdata,
	output logic periph_select,
	output logic int_rom_select,
	// External memory bus
	output logic [15:0] ext_addr,
	output logic [7:0] ext_data_out,
	output logic ext_data_oe,
	input wire logic [7:0] ext_data_in,
	output logic ext_rw_n,
	output logic display_select_n,
	output logic ram_select_n,
	output logic cartridge_select_n,
	output logic sys_rom_select_n,
	output logic [1:0] rom_page
);
	localparam int CNT_MAX = (1 << `MMD_CNT_W) - 1;
	localparam mmd_pkg::mmd_state_s RESET_S = '{
		st: mmd_pkg::ST_IDLE,
		region: mmd_pkg::RG_NONE,
		cnt: '0,
		addr: 16'h0000,
		we: 1'b0,
		dout: 8'h00,
		doe: 1'b0,
		rw_n: 1'b1,
		cs_n: `MMD_CS_IDLE,
		page: 2'h0,
		peri: 1'b0,
		irom: 1'b0,
		busy: 1'b0,
		slowed: 1'b0,
		ack: 1'b0,
		rdata: 8'h00,
		s1: 8'h00,
		s2: 8'h00,
		s3: 8'h00,
		dstab: 8'h00
	};

	// Read data from pins need three sync stages plus one to settle.
	if (BASE_CYC < 4 || BASE_CYC * ((1 << DIV_W) - 1) > CNT_MAX
		|| `MMD_DISP_MIN_CYC > CNT_MAX) begin : g_bad_param
		$error("mmd_decoder: cycle counts do not fit the access counter");
	end

	function automatic mmd_pkg::mmd_region_e region_of(input logic [15:0] a);
		logic [4:0] t;
		t = a[15:11];
		if (a < `MMD_IRAM_END) begin
			region_of = mmd_pkg::RG_IRAM;
		end else if (a >= `MMD_PERI_BASE && a < `MMD_PERI_END) begin
			region_of = mmd_pkg::RG_PERI;
		end else if (t == `MMD_TOP5_IO0 || t == `MMD_TOP5_IO1) begin
			region_of = mmd_pkg::RG_DISP;
		end else if (t[4:2] == `MMD_TOP3_XRAM) begin
			region_of = mmd_pkg::RG_XRAM;
		end else if (t[4:3] == `MMD_TOP2_CART0 || t[4:3] == `MMD_TOP2_CART1) begin
			region_of = mmd_pkg::RG_CART;
		end else if (t[4:2] == `MMD_TOP3_SROM) begin
			region_of = mmd_pkg::RG_SROM;
		end else if (t[4:1] == `MMD_TOP4_IROM) begin
			region_of = mmd_pkg::RG_IROM;
		end else begin
			region_of = mmd_pkg::RG_NONE;
		end
	endfunction

	function automatic logic [3:0] cs_of(input mmd_pkg::mmd_region_e r);
		logic [3:0] c;
		c = `MMD_CS_IDLE;
		case (r)
			mmd_pkg::RG_DISP: c[`MMD_CS_DISP] = 1'b0;
			mmd_pkg::RG_XRAM: c[`MMD_CS_XRAM] = 1'b0;
			mmd_pkg::RG_CART: c[`MMD_CS_CART] = 1'b0;
			mmd_pkg::RG_SROM: c[`MMD_CS_SROM] = 1'b0;
			default: c = `MMD_CS_IDLE;
		endcase
		return c;
	endfunction

	function automatic logic is_ext(input mmd_pkg::mmd_region_e r);
		return r == mmd_pkg::RG_DISP || r == mmd_pkg::RG_XRAM
			|| r == mmd_pkg::RG_CART || r == mmd_pkg::RG_SROM;
	endfunction

	// The slow range is wired to the system ROM window and the display region and cannot be moved.
	function automatic logic [`MMD_CNT_W-1:0] acc_cycles(input mmd_pkg::mmd_region_e r,
		input logic [DIV_W-1:0] div);
		logic [`MMD_CNT_W-1:0] n;
		logic [`MMD_CNT_W-1:0] d;
		d = (div == '0) ? `MMD_CNT_W'(1) : `MMD_CNT_W'(div);
		n = `MMD_CNT_W'(BASE_CYC);
		if (r == mmd_pkg::RG_SROM || r == mmd_pkg::RG_DISP) begin
			n = `MMD_CNT_W'(BASE_CYC * d);
		end
		if (r == mmd_pkg::RG_DISP && n < `MMD_CNT_W'(`MMD_DISP_MIN_CYC)) begin
			n = `MMD_CNT_W'(`MMD_DISP_MIN_CYC);
		end
		return n;
	endfunction

	mmd_pkg::mmd_state_s s_q;
	mmd_pkg::mmd_state_s s_d;
	mmd_pkg::mmd_region_e rg;
	logic ram_we;
	logic [7:0] ram_rdata;

	// Write lands in the last busy cycle so an aborted decode never corrupts memory.
	assign ram_we = s_q.st == mmd_pkg::ST_BUSY && s_q.cnt == `MMD_CNT_W'(1)
		&& s_q.region == mmd_pkg::RG_IRAM && s_q.we;

	mmd_ram #(
		.AW(`MMD_IRAM_AW),
		.DW(8)
	) u_ram (
		.mclk(mclk),
		.rst_b(rst_b),
		.ce(ce),
		.we(ram_we),
		.addr(s_q.addr[`MMD_IRAM_AW-1:0]),
		.wdata(s_q.dout),
		.rdata(ram_rdata)
	);

	always_comb begin
		rg = region_of(cpu_addr);
		s_d = s_q;
		s_d.s1 = ext_data_in;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		if (s_q.s2 == s_q.s3) begin
			s_d.dstab = s_q.s3;
		end
		s_d.page = rom_page_sel;
		s_d.ack = 1'b0;
		case (s_q.st)
			mmd_pkg::ST_IDLE: begin
				if (cpu_req) begin
					s_d.st = mmd_pkg::ST_BUSY;
					s_d.region = rg;
					s_d.addr = cpu_addr;
					s_d.we = cpu_we;
					s_d.dout = cpu_wdata;
					s_d.doe = cpu_we && is_ext(rg);
					s_d.rw_n = !cpu_we;
					s_d.cs_n = cs_of(rg);
					s_d.peri = rg == mmd_pkg::RG_PERI;
					s_d.irom = rg == mmd_pkg::RG_IROM;
					s_d.cnt = acc_cycles(rg, clk_div);
					s_d.busy = 1'b1;
					s_d.slowed = acc_cycles(rg, clk_div) != `MMD_CNT_W'(BASE_CYC);
				end
			end
			mmd_pkg::ST_BUSY: begin
				s_d.cnt = s_q.cnt - `MMD_CNT_W'(1);
				if (s_q.cnt == `MMD_CNT_W'(1)) begin
					s_d.st = mmd_pkg::ST_IDLE;
					s_d.ack = 1'b1;
					case (s_q.region)
						mmd_pkg::RG_IRAM: s_d.rdata = ram_rdata;
						mmd_pkg::RG_PERI: s_d.rdata = int_rdata;
						mmd_pkg::RG_IROM: s_d.rdata = int_rdata;
						mmd_pkg::RG_NONE: s_d.rdata = 8'h00;
						default: s_d.rdata = s_q.dstab;
					endcase
					s_d.cs_n = `MMD_CS_IDLE;
					s_d.rw_n = 1'b1;
					s_d.doe = 1'b0;
					s_d.peri = 1'b0;
					s_d.irom = 1'b0;
					s_d.busy = 1'b0;
					s_d.slowed = 1'b0;
				end
			end
			default: s_d.st = mmd_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= RESET_S;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign cpu_ack = s_q.ack;
	assign cpu_rdata = s_q.rdata;
	assign cpu_busy = s_q.busy;
	assign cpu_slowed = s_q.slowed;
	assign periph_select = s_q.peri;
	assign int_rom_select = s_q.irom;
	assign ext_addr = s_q.addr;
	assign ext_data_out = s_q.dout;
	assign ext_data_oe = s_q.doe;
	assign ext_rw_n = s_q.rw_n;
	assign display_select_n = s_q.cs_n[`MMD_CS_DISP];
	assign ram_select_n = s_q.cs_n[`MMD_CS_XRAM];
	assign cartridge_select_n = s_q.cs_n[`MMD_CS_CART];
	assign sys_rom_select_n = s_q.cs_n[`MMD_CS_SROM];
	assign rom_page = s_q.page;

	// Checks below assume the default parameter values.
	localparam int FAST_A = `MMD_BASE_CYC + 1;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b || !ce);

	logic take;
	logic [15:0] exp_q;
	logic [15:0] run_q;
	logic [15:0] exp_n;
	assign take = s_q.st == mmd_pkg::ST_IDLE && cpu_req;
	always_comb begin
		exp_n = 16'(BASE_CYC);
		if (rg == mmd_pkg::RG_SROM || rg == mmd_pkg::RG_DISP) begin
			exp_n = 16'(BASE_CYC) * ((clk_div == '0) ? 16'h0001 : 16'(clk_div));
		end
		if (rg == mmd_pkg::RG_DISP && exp_n < 16'(`MMD_DISP_MIN_CYC)) begin
			exp_n = 16'(`MMD_DISP_MIN_CYC);
		end
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			exp_q <= 16'h0000;
			run_q <= 16'h0000;
		end else if (ce) begin
			if (take) begin
				exp_q <= exp_n;
				run_q <= 16'h0000;
			end else if (s_q.busy) begin
				run_q <= run_q + 16'h0001;
			end
		end
	end

	acc_len_a: assert property (cpu_ack |-> run_q == exp_q)
		else $error("access length does not match region and divide ratio");
	fast_xram_a: assert property (take && rg == mmd_pkg::RG_XRAM |-> ##FAST_A cpu_ack)
		else $error("external RAM access not at undivided rate");
	unused_quiet_a: assert property (s_q.busy && s_q.addr[15:12] == 4'hE |->
		s_q.cs_n == `MMD_CS_IDLE && !ram_we && !periph_select && !int_rom_select)
		else $error("unassigned region raised a select");
	disp_sel_a: assert property (take && cpu_addr[15:12] == 4'h1 |=>
		!display_select_n && ram_select_n && cartridge_select_n && sys_rom_select_n)
		else $error("display select wrong for I/O region");
	xram_sel_a: assert property (take && cpu_addr[15:13] == 3'h1 |=>
		!ram_select_n && display_select_n && sys_rom_select_n)
		else $error("external RAM select wrong");
	cart_sel_a: assert property (take && (cpu_addr[15:14] == 2'h1 || cpu_addr[15:14] == 2'h2)
		|=> !cartridge_select_n && ext_rw_n == !$past(cpu_we))
		else $error("cartridge select or direction wrong");
	srom_sel_a: assert property (take && cpu_addr[15:13] == 3'h6 |=>
		!sys_rom_select_n && cpu_slowed == ($past(clk_div) > 1))
		else $error("system ROM select or slow flag wrong");
	int_sel_a: assert property (take && (cpu_addr < 16'h0080 || cpu_addr[15:12] == 4'hF) |=>
		sys_rom_select_n && ram_select_n && !periph_select)
		else $error("on-chip region drove an external select");
	peri_sel_a: assert property (take && cpu_addr[15:7] == 9'h002 |=> periph_select)
		else $error("peripheral select missing");
	page_fwd_a: assert property (##1 rom_page == $past(rom_page_sel))
		else $error("ROM page lines do not follow page select");
	addr_out_a: assert property (take |=> ext_addr == $past(cpu_addr)
		##1 ext_addr == $past(cpu_addr, 2))
		else $error("address bus not held during access");
	ack_once_a: assert property (cpu_ack && !take |=> !cpu_ack && !cpu_busy)
		else $error("acknowledge longer than one cycle");
	idle_quiet_a: assert property (!cpu_busy |->
		s_q.cs_n == `MMD_CS_IDLE && ext_rw_n && !ext_data_oe)
		else $error("select or write strobe active while idle");

	// The default disable masks every cycle with ce low, so the freeze check carries its own.
	ce_freeze_a: assert property (@(posedge mclk) disable iff (!rst_b) !ce |=>
		$stable({s_q.st, s_q.cnt, s_q.cs_n, s_q.busy, s_q.dstab}))
		else $error("state moved while clock enable was low");

	disp_done_c: cover property (take && rg == mmd_pkg::RG_DISP ##[1:300] cpu_ack);
	slow_rom_c: cover property (take && rg == mmd_pkg::RG_SROM && clk_div > 1 ##[1:200] cpu_ack);
	iram_rd_c: cover property (take && rg == mmd_pkg::RG_IRAM && !cpu_we ##FAST_A cpu_ack);
	hold_c: cover property (@(posedge mclk) disable iff (!rst_b) s_q.busy && !ce ##1 ce);
	unused_c: cover property (take && rg == mmd_pkg::RG_NONE);
endmodule

/* File: tb/mmd_ext_model.sv */
`timescale 1ns/1ps
module mmd_ext_model (
	// Clock
	input wire logic mclk,
	// Bus from the decoder
	input wire logic [15:0] ext_addr,
	input wire logic [7:0] ext_data_out,
	input wire logic ext_data_oe,
	input wire logic ext_rw_n,
	input wire logic display_select_n,
	input wire logic ram_select_n,
	input wire logic cartridge_select_n,
	input wire logic sys_rom_select_n,
	input wire logic [1:0] rom_page,
	// Data pins back to the decoder
	output logic [7:0] ext_data_in
);
	// Only 8K of the cartridge is modelled, so its upper part mirrors the lower.
	logic [7:0] ram [0:8191];
	logic [7:0] cart [0:8191];
	logic [7:0] disp_q = 8'h00;
	logic [7:0] last_q = 8'h00;

	always_ff @(posedge mclk) begin
		if (!ext_rw_n && ext_data_oe) begin
			if (!ram_select_n) ram[ext_addr[12:0]] <= ext_data_out;
			if (!cartridge_select_n) cart[ext_addr[12:0]] <= ext_data_out;
			if (!display_select_n) disp_q <= ext_data_out;
		end
		last_q <= ext_data_in;
	end

	// Released pins toggle every cycle so a stale value never looks valid.
	always_comb begin
		ext_data_in = ~last_q;
		if (ext_rw_n) begin
			if (!ram_select_n) ext_data_in = ram[ext_addr[12:0]];
			if (!cartridge_select_n) ext_data_in = cart[ext_addr[12:0]];
			if (!sys_rom_select_n) ext_data_in = {rom_page, ext_addr[5:0]};
			if (!display_select_n) ext_data_in = disp_q;
		end
	end
endmodule

/* File: tb/test_mmd_decoder.sv */
`timescale 1ns/1ps
module test_mmd_decoder;
	logic mclk = 0, rst_b = 0, ce = 1, cpu_req = 0, cpu_we = 0;
	logic [15:0] cpu_addr = 16'h0000;
	logic [7:0] cpu_wdata = 8'h00, int_rdata = 8'h5A, ext_data_in, cpu_rdata, ext_data_out;
	logic [3:0] clk_div = 4'h1, sel;
	logic [1:0] rom_page_sel = 2'h0, rom_page;
	logic cpu_ack, cpu_busy, cpu_slowed, periph_select, int_rom_select, ext_data_oe, ext_rw_n;
	logic display_select_n, ram_select_n, cartridge_select_n, sys_rom_select_n;
	logic [15:0] ext_addr;
	logic [7:0] rd;
	logic peri, irom, slow, rwn, oe, bsy;
	int n, mismatches = 0, tests_run = 0;

	mmd_decoder DUT (.mclk(mclk), .rst_b(rst_b), .ce(ce), .cpu_req(cpu_req), .cpu_we(cpu_we),
		.cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata),
		.cpu_busy(cpu_busy), .cpu_slowed(cpu_slowed), .clk_div(clk_div),
		.rom_page_sel(rom_page_sel), .int_rdata(int_rdata), .periph_select(periph_select),
		.int_rom_select(int_rom_select), .ext_addr(ext_addr), .ext_data_out(ext_data_out),
		.ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in), .ext_rw_n(ext_rw_n),
		.display_select_n(display_select_n), .ram_select_n(ram_select_n),
		.cartridge_select_n(cartridge_select_n), .sys_rom_select_n(sys_rom_select_n),
		.rom_page(rom_page));

	mmd_ext_model far_side (.mclk(mclk), .ext_addr(ext_addr), .ext_data_out(ext_data_out),
		.ext_data_oe(ext_data_oe), .ext_rw_n(ext_rw_n), .display_select_n(display_select_n),
		.ram_select_n(ram_select_n), .cartridge_select_n(cartridge_select_n),
		.sys_rom_select_n(sys_rom_select_n), .rom_page(rom_page), .ext_data_in(ext_data_in));

	initial begin
		forever #20 mclk = ~mclk;
	end

	task check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task end_of_test;
		$display("checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// One access; n counts edges from the taking edge to the acknowledge.
	task access(input logic we, input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1;
		cpu_req = 1;
		cpu_we = we;
		cpu_addr = a;
		cpu_wdata = d;
		@(posedge mclk);
		#1;
		cpu_req = 0;
		n = 1;
		sel = {display_select_n, ram_select_n, cartridge_select_n, sys_rom_select_n};
		peri = periph_select;
		irom = int_rom_select;
		slow = cpu_slowed;
		rwn = ext_rw_n;
		oe = ext_data_oe;
		bsy = cpu_busy;
		while (cpu_ack !== 1'b1 && n < 200) begin
			@(posedge mclk);
			#1;
			n++;
		end
		rd = cpu_rdata;
	endtask

	task sc_reset;
		check(16'({display_select_n, ram_select_n, cartridge_select_n, sys_rom_select_n}),
			16'h000F);
		check(16'({cpu_busy, ext_rw_n, ext_data_oe}), 16'h0002);
	endtask

	task sc_map;
		logic [15:0] ma [12];
		logic [3:0] ms [12];
		int len;
		ma = '{16'h0010, 16'h0080, 16'h0100, 16'h017F, 16'h1000, 16'h1FFF, 16'h2000,
			16'h4000, 16'hBFFF, 16'hC000, 16'hE000, 16'hF000};
		ms = '{4'hF, 4'hF, 4'hF, 4'hF, 4'h7, 4'h7, 4'hB, 4'hD, 4'hD, 4'hE, 4'hF, 4'hF};
		for (int i = 0; i < 12; i++) begin
			len = (i == 4 || i == 5) ? 93 : 6;
			access(1'b0, ma[i], 8'h00);
			check(16'(sel), 16'(ms[i]));
			check({peri, irom}, {14'h0000, i == 2 || i == 3, i == 11});
			check(16'(n), 16'(len + 1));
			check(16'(slow), 16'(len != 6));
			check(16'({bsy, cpu_busy}), 16'h0002);
			if (i == 1 || i == 10) check(16'(rd), 16'h0000);
			if (i == 2 || i == 11) check(16'(rd), 16'h005A);
		end
	endtask

	task sc_data;
		logic [15:0] da [4];
		logic [7:0] dv [4];
		da = '{16'h2345, 16'h4567, 16'h0042, 16'h1001};
		dv = '{8'hC3, 8'h3C, 8'h99, 8'h7E};
		for (int i = 0; i < 4; i++) begin
			access(1'b1, da[i], dv[i]);
			check(16'(rwn), 16'h0000);
			check(ext_addr, da[i]);
			check(16'(ext_data_out), 16'(dv[i]));
			check(16'(oe), 16'(i != 2));
		end
		access(1'b1, 16'hE345, 8'h00);
		check(16'(sel), 16'h000F);
		check(16'(oe), 16'h0000);
		for (int i = 0; i < 4; i++) begin
			access(1'b0, da[i], 8'h00);
			check(16'(rd), 16'(dv[i]));
		end
	endtask

	task sc_page;
		logic [3:0] dl [4];
		dl = '{4'h0, 4'h1, 4'h2, 4'hF};
		for (int p = 0; p < 4; p++) begin
			rom_page_sel = 2'(p);
			repeat (2) @(posedge mclk);
			#1;
			check(16'(rom_page), 16'(p));
			access(1'b0, 16'hC005, 8'h00);
			check(16'(rd), {8'h00, 2'(p), 6'h05});
		end
		for (int i = 0; i < 4; i++) begin
			clk_div = dl[i];
			access(1'b0, 16'hC000, 8'h00);
			check(16'(n), 16'(6 * (dl[i] == 0 ? 1 : dl[i]) + 1));
			access(1'b0, 16'h1002, 8'h00);
			check(16'(n), 16'(94));
			access(1'b0, 16'h2000, 8'h00);
			check(16'(n), 16'(7));
		end
	endtask

	// An external RAM read frozen for ten cycles by ce must resume where it stopped.
	task sc_hold;
		@(posedge mclk);
		#1;
		cpu_req = 1;
		cpu_we = 0;
		cpu_addr = 16'h2345;
		@(posedge mclk);
		#1;
		cpu_req = 0;
		ce = 0;
		repeat (10) @(posedge mclk);
		#1;
		check(16'({cpu_busy, ram_select_n, cpu_ack}), 16'h0004);
		ce = 1;
		n = 0;
		while (cpu_ack !== 1'b1 && n < 200) begin
			@(posedge mclk);
			#1;
			n++;
		end
		check(16'(n), 16'(6));
		check(16'(cpu_rdata), 16'h00C3);
	endtask

	initial begin
		repeat (16) @(posedge mclk);
		#1;
		rst_b = 1;
		sc_reset();
		sc_map();
		sc_data();
		sc_hold();
		sc_page();
		end_of_test();
	end

	// The whole sequence needs a little over a thousand cycles; allow ample margin.
	initial begin
		#(40 * 30000);
		mismatches++;
		end_of_test();
	end
endmodule
